// >>> answerback_auto_linefeed.sv
// Answerback message sender with transmit and receive line-feed insertion
`timescale 1ns/1ps
`default_nettype none
`include "ab_cfg.svh"

module tx_fifo #(
  parameter int W = 9,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Honest full and empty flags
  assign in_ready_o  = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tx_fifo

module answerback_auto_linefeed #(
  parameter int MSG_LEN    = `MSG_LEN,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rstn_i,
  // Keyboard side
  input  wire logic [`CHAR_W-1:0]           kbd_data_i,
  input  wire logic                         kbd_strobe_i,
  output logic                              kbd_ready_o,
  // UART transmit side
  output logic [`CHAR_W-1:0]                uart_tx_data_o,
  output logic                              uart_kstrb_o,
  input  wire logic                         xmit_rdy_i,
  // Receive side and character buffer lines
  input  wire logic [`CHAR_W-1:0]           rx_data_i,
  output logic [`CHAR_W-1:0]                rx_data_o,
  output logic                              rx_data_oe_o,
  input  wire logic                         uart_da_i,
  input  wire logic                         clr_da_i,
  output logic                              uart_out_en_o,
  output logic                              option_data_avail_out_o,
  // Switches, jumpers and gating
  input  wire logic                         answerback_request_key_i,
  input  wire logic                         local_mode_i,
  input  wire logic                         auto_newline_switch_i,
  input  wire logic                         tx_insert_jumper_i,
  input  wire logic                         rx_insert_jumper_i,
  input  wire logic [1:0]                   trilevel_transmit_gate_i,
  input  wire logic [MSG_LEN*`CHAR_W-1:0]   message_i,
  // Status
  output logic                              ab_busy_o,
  output logic                              tx_lf_busy_o,
  output logic                              rx_lf_busy_o
);
  import ab_pkg::*;
  localparam int SW = 2 * `CHAR_W + 11 + MSG_LEN * `CHAR_W;
  logic [SW-1:0]            s1_q;
  logic [SW-1:0]            s2_q;
  logic [`CHAR_W-1:0]       kbd_data;
  logic [`CHAR_W-1:0]       rx_data;
  logic [MSG_LEN*`CHAR_W-1:0] msg;
  logic                     kbd_stb;
  logic                     xrdy;
  logic                     da;
  logic                     clr;
  logic                     key;
  logic                     loc;
  logic                     auto_sw;
  logic                     tx_jmp;
  logic                     rx_jmp;
  logic [1:0]               gate;
  logic [4:0]               prev_q;
  logic                     kbd_edge;
  logic                     xrdy_rise;
  logic                     da_rise;
  logic                     clr_rise;
  logic                     key_rise;
  logic                     permit;
  logic                     cts;
  tx_state_t                tx_q;
  rx_state_t                rx_q;
  ab_state_t                ab_q;
  drain_state_t             dr_q;
  logic [`SEL_W-1:0]        sel_q;
  logic [`CHAR_W-1:0]       ab_char;
  tx_word_t                 fifo_in;
  tx_word_t                 fifo_out;
  logic                     fifo_in_valid;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic                     fifo_pop;
  src_t                     sent_src_q;
  logic                     accepted;
  logic                     kbd_push;
  logic                     lf_push;
  logic                     ab_push;
  logic                     kbd_block;

  // Two-flop synchronisers for every pin input except clock and reset
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {kbd_data_i, rx_data_i, kbd_strobe_i, xmit_rdy_i, uart_da_i, clr_da_i,
               answerback_request_key_i, local_mode_i, auto_newline_switch_i,
               tx_insert_jumper_i, rx_insert_jumper_i, trilevel_transmit_gate_i, message_i};
      s2_q <= s1_q;
    end
  end

  // Unpack the synchronised inputs
  assign {kbd_data, rx_data, kbd_stb, xrdy, da, clr, key, loc, auto_sw,
          tx_jmp, rx_jmp, gate, msg} = s2_q;
  // Edge detection on the synchronised strobes, previous levels in one word
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      prev_q <= 5'h00;
    end else begin
      prev_q <= {kbd_stb, xrdy, da, clr, key};
    end
  end
  assign kbd_edge  = kbd_stb && !prev_q[4];
  assign xrdy_rise = xrdy && !prev_q[3];
  assign da_rise   = da && !prev_q[2];
  assign clr_rise  = clr && !prev_q[1];
  assign key_rise  = key && !prev_q[0];
  // Gating: local mode always permits; middle level only latches
  assign permit = loc || (gate != `GATE_INHIBIT);
  assign cts    = loc || (gate == `GATE_OPEN);
  // Keyboard path blocked during insertion or message
  assign kbd_block   = (tx_q != TX_IDLE) || (ab_q != AB_IDLE);
  assign kbd_ready_o = fifo_in_ready && !kbd_block;
  assign kbd_push    = kbd_edge && kbd_ready_o;
  assign lf_push     = (tx_q == TX_PUSH) && cts;
  assign ab_char     = msg[(32'(sel_q) - 1) * `CHAR_W +: `CHAR_W];
  assign ab_push     = (ab_q == AB_SEND) && cts && (ab_char != `CODE_NUL)
                       && (sel_q != '0) && !lf_push; // A queued line feed owns the slot
  // Source selection into the transmit FIFO
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in.src   = SRC_KBD;
    fifo_in.code  = kbd_data;
    if (lf_push) begin
      fifo_in_valid = 1'b1;
      fifo_in.src   = SRC_TXLF;
      fifo_in.code  = `CODE_LF;
    end else if (ab_push) begin
      fifo_in_valid = 1'b1;
      fifo_in.src   = SRC_AB;
      fifo_in.code  = ab_char;
    end else if (kbd_push) begin
      fifo_in_valid = 1'b1;
    end
  end
  tx_fifo #(
    .W ($bits(tx_word_t)),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );
  // Drain to UART: strobe when ready, wait for busy then ready again
  assign fifo_pop = (dr_q == DR_IDLE) && xrdy && fifo_out_valid;
  assign accepted = (dr_q == DR_READY) && xrdy_rise;
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dr_q           <= DR_IDLE;
      uart_tx_data_o <= '0;
      uart_kstrb_o   <= 1'b0;
      sent_src_q     <= SRC_KBD;
    end else begin
      uart_kstrb_o <= fifo_pop;
      case (dr_q)
        DR_IDLE: begin
          if (fifo_pop) begin
            uart_tx_data_o <= fifo_out.code;
            sent_src_q     <= fifo_out.src;
            dr_q           <= DR_BUSY;
          end
        end
        DR_BUSY: begin
          if (!xrdy) begin
            dr_q <= DR_READY;
          end
        end
        DR_READY: begin
          if (xrdy_rise) begin
            dr_q <= DR_IDLE;
          end
        end
        default: dr_q <= DR_IDLE;
      endcase
    end
  end

  // Transmit line-feed insertion after a typed return
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tx_q <= TX_IDLE;
    end else begin
      case (tx_q)
        TX_IDLE: begin
          if (kbd_push && kbd_data == `CODE_CR && auto_sw && tx_jmp) begin
            tx_q <= TX_ARMED;
          end
        end
        TX_ARMED: begin
          if (accepted && sent_src_q == SRC_KBD) begin
            tx_q <= TX_PUSH;
          end
        end
        TX_PUSH: begin
          if (lf_push && fifo_in_ready) begin
            tx_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (accepted && sent_src_q == SRC_TXLF) begin
            tx_q <= TX_IDLE;
          end
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  // Answerback request latch and character sequencing
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ab_q  <= AB_IDLE;
      sel_q <= '0;
    end else begin
      case (ab_q)
        AB_IDLE: begin
          if ((key_rise || (da_rise && rx_data == `CODE_ENQ)) && permit) begin
            ab_q <= AB_PEND;
          end
        end
        AB_PEND: begin
          if (!permit) begin
            ab_q <= AB_IDLE;
          end else if (cts) begin
            sel_q <= `SEL_W'(1);
            ab_q  <= AB_SEND;
          end
        end
        AB_SEND: begin
          if (ab_char == `CODE_NUL) begin
            sel_q <= '0;
            ab_q  <= AB_IDLE;
          end else if (ab_push && fifo_in_ready) begin
            ab_q <= AB_WAIT;
          end
        end
        AB_WAIT: begin
          if (accepted && sent_src_q == SRC_AB) begin
            if (sel_q == `SEL_W'(MSG_LEN)) begin
              sel_q <= '0;
              ab_q  <= AB_IDLE;
            end else begin
              sel_q <= sel_q + 1'b1;
              ab_q  <= AB_SEND;
            end
          end
        end
        default: ab_q <= AB_IDLE;
      endcase
    end
  end

  // Receive line-feed insertion after a received return
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rx_q <= RX_IDLE;
    end else begin
      case (rx_q)
        RX_IDLE: begin
          if (da_rise && rx_data == `CODE_CR && rx_jmp) begin
            rx_q <= RX_CR;
          end
        end
        RX_CR: begin
          if (clr_rise) begin
            rx_q <= RX_LF;
          end
        end
        RX_LF: begin
          if (clr_rise) begin
            rx_q <= RX_IDLE;
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  // Buffer-line drive and option data-available, from flip-flops
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rx_data_o               <= '0;
      rx_data_oe_o            <= 1'b0;
      uart_out_en_o           <= 1'b1;
      option_data_avail_out_o <= 1'b0;
    end else begin
      rx_data_o               <= `CODE_LF;
      rx_data_oe_o            <= (rx_q == RX_LF);
      uart_out_en_o           <= (rx_q != RX_LF);
      option_data_avail_out_o <= (rx_q == RX_LF);
    end
  end

  // Status outputs
  assign ab_busy_o    = (ab_q != AB_IDLE);
  assign tx_lf_busy_o = (tx_q != TX_IDLE);
  assign rx_lf_busy_o = (rx_q != RX_IDLE);
endmodule : answerback_auto_linefeed
`default_nettype wire

// >>> ab_cfg.svh
// Constants for the answerback and automatic line-feed block
// Functional notes
// - Switch message of twenty positions, spaces count
// - Start message on request key or ENQ
// - On-line sends to line, local prints locally
// - Answer only when gating line permits it
// - Local mode ignores the gating line entirely
// - Keyboard passes through, blocked while inserting
// - Typed return with switch, jumper inserts LF
// - LF keystrobe only while clear-to-send high
// - LF accepted, restore the keyboard path
// - No transmit jumper, no transmit insertion
// - Received return processed, then disable UART
// - Drive LF on buffer lines while disabled
// - Assert own data-available with inserted LF
// - LF processed, release lines, enable UART
// - No receive jumper, no receive insertion
// - Request blocks keyboard, steps selector, strobes
// - Message goes out on keyboard lines only
// - Each accepted character brings the next
// - Inserted code is line feed, bits 2,4
// - All-zero position ends the message
// - Middle gate level holds request, sends nothing
// - Requests ignored while message in progress
`ifndef AB_CFG_SVH
`define AB_CFG_SVH
`define CHAR_W       7
`define MSG_LEN      20
`define SEL_W        5
`define CODE_LF      7'h0A
`define CODE_CR      7'h0D
`define CODE_ENQ     7'h05
`define CODE_NUL     7'h00
`define GATE_INHIBIT 2'h0
`define GATE_HOLD    2'h1
`define GATE_OPEN    2'h2
`define FIFO_DEPTH   4
`endif

// >>> ab_pkg.sv
// Types for the answerback and automatic line-feed block
package ab_pkg;
  typedef enum logic [1:0] {SRC_KBD, SRC_TXLF, SRC_AB} src_t;
  typedef struct packed {
    src_t       src;
    logic [6:0] code;
  } tx_word_t;
  typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_PUSH, TX_WAIT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_CR, RX_LF} rx_state_t;
  typedef enum logic [1:0] {AB_IDLE, AB_PEND, AB_SEND, AB_WAIT} ab_state_t;
  typedef enum logic [1:0] {DR_IDLE, DR_BUSY, DR_READY} drain_state_t;
endpackage : ab_pkg

// >>> answerback_auto_linefeed_asserts.sv
// Port checker for the answerback and line-feed block
`timescale 1ns/1ps
`default_nettype none
module answerback_auto_linefeed_asserts (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  // Watched ports
  input wire logic       kbd_ready_o,
  input wire logic       uart_kstrb_o,
  input wire logic [6:0] rx_data_o,
  input wire logic       rx_data_oe_o,
  input wire logic       uart_out_en_o,
  input wire logic       option_data_avail_out_o,
  input wire logic       tx_insert_jumper_i,
  input wire logic       rx_insert_jumper_i,
  input wire logic       ab_busy_o,
  input wire logic       tx_lf_busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Receive insertion owns the buffer lines
  property p_lf; rx_data_oe_o |-> rx_data_o == 7'h0A; endproperty
  a_lf: assert property (p_lf) else $error("bad lf code");
  property p_own; rx_data_oe_o |-> !uart_out_en_o; endproperty
  a_own: assert property (p_own) else $error("uart not off");
  property p_da; option_data_avail_out_o == rx_data_oe_o; endproperty
  a_da: assert property (p_da) else $error("avail unpaired");
  property p_rel; $fell(rx_data_oe_o) |-> uart_out_en_o; endproperty
  a_rel: assert property (p_rel) else $error("uart not back");
  property p_rj; rx_data_oe_o |-> rx_insert_jumper_i; endproperty
  a_rj: assert property (p_rj) else $error("rx insert off");
  // Transmit side
  property p_tj; tx_lf_busy_o |-> tx_insert_jumper_i; endproperty
  a_tj: assert property (p_tj) else $error("tx insert off");
  property p_blk; tx_lf_busy_o |-> !kbd_ready_o; endproperty
  a_blk: assert property (p_blk) else $error("kbd open");
  property p_stb; uart_kstrb_o |=> !uart_kstrb_o [*3]; endproperty
  a_stb: assert property (p_stb) else $error("strobe early");
  c_rx: cover property ($rose(rx_data_oe_o));
  c_ab: cover property ($rose(ab_busy_o));
  c_tx: cover property ($rose(tx_lf_busy_o));
endmodule : answerback_auto_linefeed_asserts

bind answerback_auto_linefeed answerback_auto_linefeed_asserts u_chk (.ref_clk_i, .rstn_i,
  .kbd_ready_o, .uart_kstrb_o, .rx_data_o, .rx_data_oe_o, .uart_out_en_o,
  .option_data_avail_out_o, .tx_insert_jumper_i, .rx_insert_jumper_i, .ab_busy_o,
  .tx_lf_busy_o);
`default_nettype wire

// >>> uart_tx_model.sv
// Transmitter model answering each keystrobe with a ready handshake
`timescale 1ns/1ps
`default_nettype none
module uart_tx_model (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // Keystrobe in, ready out
  input  wire logic kstrb_i,
  input  wire logic slow_i,
  output logic      xmit_rdy_o
);
  int unsigned busy_cnt;
  // Ready drops for a while after each keystrobe
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      xmit_rdy_o <= 1'b1;
      busy_cnt   <= 0;
    end else if (kstrb_i) begin
      xmit_rdy_o <= 1'b0;
      busy_cnt   <= slow_i ? 40 : 3;
    end else if (busy_cnt > 1) begin
      busy_cnt <= busy_cnt - 1;
    end else begin
      xmit_rdy_o <= 1'b1;
    end
  end
endmodule : uart_tx_model
`default_nettype wire

// >>> answerback_auto_linefeed_bench.sv
// Self-checking bench for the answerback and line-feed block
`timescale 1ns/1ps
`default_nettype none
module answerback_auto_linefeed_bench;
  logic         ref_clk_i, rstn_i, kbd_strobe_i, xmit_rdy_i, uart_da_i, clr_da_i, slow;
  logic         answerback_request_key_i, local_mode_i, auto_newline_switch_i, saw_full;
  logic         tx_insert_jumper_i, rx_insert_jumper_i, kbd_ready_o, uart_kstrb_o;
  logic         rx_data_oe_o, uart_out_en_o, option_data_avail_out_o, ab_busy_o;
  logic         tx_lf_busy_o, rx_lf_busy_o;
  logic [1:0]   trilevel_transmit_gate_i;
  logic [6:0]   kbd_data_i, uart_tx_data_o, rx_data_o, rx_val, exp_q[$], got_q[$];
  wire  [6:0]   rx_data_i;
  logic [139:0] message_i;
  logic [31:0]  lfsr = 32'hF7AD;
  int           error_cnt, check_count, cyc;
  // Design and transmitter model
  answerback_auto_linefeed u_dut (.ref_clk_i, .rstn_i, .kbd_data_i, .kbd_strobe_i,
    .kbd_ready_o, .uart_tx_data_o, .uart_kstrb_o, .xmit_rdy_i, .rx_data_i, .rx_data_o,
    .rx_data_oe_o, .uart_da_i, .clr_da_i, .uart_out_en_o, .option_data_avail_out_o,
    .answerback_request_key_i, .local_mode_i, .auto_newline_switch_i, .tx_insert_jumper_i,
    .rx_insert_jumper_i, .trilevel_transmit_gate_i, .message_i, .ab_busy_o, .tx_lf_busy_o,
    .rx_lf_busy_o);
  uart_tx_model u_uart (.ref_clk_i, .rstn_i, .kstrb_i(uart_kstrb_o), .slow_i(slow),
    .xmit_rdy_o(xmit_rdy_i));
  // Released buffer lines show the inverse of the last UART value
  assign rx_data_i = uart_out_en_o ? rx_val : (rx_data_oe_o ? rx_data_o : ~rx_val);
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // Cycle ceiling and capture of every character sent to the UART
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
    if (rstn_i && uart_kstrb_o === 1'b1) begin
      got_q.push_back(uart_tx_data_o);
      if (ab_busy_o) chk("ab_lines", {kbd_ready_o, rx_data_oe_o}, 0);
    end
  end
  function automatic logic [6:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return {2'b10, lfsr[4:0]};
  endfunction : rnd
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic cy(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cy
  task automatic pulse(ref logic s);
    s = 1'b1;
    cy(3);
    s = 1'b0;
    cy(3);
  endtask : pulse
  // Typed key, waiting while the keyboard path is refused
  task automatic key(logic [6:0] c);
    for (int i = 0; i < 900 && kbd_ready_o !== 1'b1; i++) begin
      saw_full = 1'b1;
      cy(1);
    end
    kbd_data_i = c;
    exp_q.push_back(c);
    if (c == 7'h0D && tx_insert_jumper_i && auto_newline_switch_i) exp_q.push_back(7'h0A);
    pulse(kbd_strobe_i);
  endtask : key
  task automatic ab_exp();
    for (int i = 0; i < 20; i++) begin
      if (message_i[i*7 +: 7] == 7'h00) break;
      exp_q.push_back(message_i[i*7 +: 7]);
    end
  endtask : ab_exp
  // Wait for a quiet line, then compare sent characters with the model
  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 4000 && q < 80; i++) begin
      q = (ab_busy_o === 1'b0 && tx_lf_busy_o === 1'b0 && xmit_rdy_i) ? q + 1 : 0;
      cy(1);
    end
    chk("sent", got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) chk("char", got_q[i], exp_q[i]);
    exp_q.delete();
    got_q.delete();
  endtask : settle
  initial begin
    {rstn_i, kbd_strobe_i, uart_da_i, clr_da_i, answerback_request_key_i, local_mode_i} = 6'h00;
    {auto_newline_switch_i, tx_insert_jumper_i, rx_insert_jumper_i, slow} = 4'hE;
    kbd_data_i = 7'h00;
    rx_val = 7'h00;
    trilevel_transmit_gate_i = 2'h2;
    message_i = '0;
    saw_full = 1'b0;
    cy(2);
    rstn_i = 1'b1;
    cy(4);
    chk("idle", {kbd_ready_o, uart_out_en_o, rx_data_oe_o, option_data_avail_out_o, ab_busy_o,
                 tx_lf_busy_o, rx_lf_busy_o, uart_kstrb_o}, 8'hC0);
    // Slow transmitter: random keys fill the FIFO until it refuses
    slow = 1'b1;
    saw_full = 1'b0;
    repeat (8) key(rnd());
    settle();
    chk("full", saw_full, 1);
    slow = 1'b0;
    // Typed return with and without the transmit jumper
    key(7'h0D);
    settle();
    tx_insert_jumper_i = 1'b0;
    key(7'h0D);
    settle();
    tx_insert_jumper_i = 1'b1;
    // Message with a space and an early end, asked for twice
    for (int i = 0; i < 20; i++) message_i[i*7 +: 7] = rnd();
    message_i[13:7] = 7'h20;
    message_i[41:35] = 7'h00;
    pulse(answerback_request_key_i);
    ab_exp();
    pulse(answerback_request_key_i);
    settle();
    message_i[41:35] = rnd();
    pulse(answerback_request_key_i);
    ab_exp();
    settle();
    // Inhibited gate, then local mode overriding it
    trilevel_transmit_gate_i = 2'h0;
    pulse(answerback_request_key_i);
    settle();
    local_mode_i = 1'b1;
    pulse(answerback_request_key_i);
    ab_exp();
    key(7'h0D);
    settle();
    local_mode_i = 1'b0;
    // Middle gate holds the request until the gate opens
    trilevel_transmit_gate_i = 2'h1;
    pulse(answerback_request_key_i);
    cy(60);
    chk("held", got_q.size(), 0);
    chk("pending", ab_busy_o, 1);
    trilevel_transmit_gate_i = 2'h2;
    ab_exp();
    settle();
    // Received enquiry code
    rx_val = 7'h05;
    pulse(uart_da_i);
    pulse(clr_da_i);
    ab_exp();
    settle();
    // Received return, with and without the receive jumper
    rx_val = 7'h0D;
    pulse(uart_da_i);
    chk("wait_clr", {uart_out_en_o, rx_lf_busy_o}, 2'h3);
    pulse(clr_da_i);
    chk("insert", {rx_data_oe_o, uart_out_en_o, option_data_avail_out_o, rx_data_i},
        10'h28A);
    pulse(clr_da_i);
    chk("restore", {rx_data_oe_o, uart_out_en_o, option_data_avail_out_o}, 3'h2);
    rx_insert_jumper_i = 1'b0;
    pulse(uart_da_i);
    pulse(clr_da_i);
    chk("no_insert", rx_data_oe_o, 0);
    print_verdict();
  end
endmodule : answerback_auto_linefeed_bench
`default_nettype wire
